// ### src/vrdc_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the voltage
 * reference and supply detect control block.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef VRDC_DEFS_SVH
`define VRDC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------------
`define VRDC_ADDR_W 2
`define VRDC_OFS_LADDER 2'h0
`define VRDC_OFS_FIXED 2'h1
`define VRDC_OFS_DETECT 2'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VRDC_LAD_POWER_BIT 7
`define VRDC_LAD_PIN_BIT 6
`define VRDC_LAD_RANGE_BIT 5
`define VRDC_LAD_SOURCE_BIT 4
`define VRDC_LAD_TAP_MSB 3
`define VRDC_LAD_TAP_LSB 0
`define VRDC_FIX_ENABLE_BIT 7
`define VRDC_FIX_STABLE_BIT 6
`define VRDC_DET_DIR_BIT 7
`define VRDC_DET_STABLE_BIT 5
`define VRDC_DET_POWER_BIT 4
`define VRDC_DET_CODE_MSB 3
`define VRDC_DET_CODE_LSB 0

// ----------------------------------------------------------------------------
// Reset values and special codes
// ----------------------------------------------------------------------------
`define VRDC_LADDER_RESET 8'h00
`define VRDC_FIXED_ENABLE_RESET 1'b0
`define VRDC_DETECT_CODE_RESET 4'h5
`define VRDC_DETECT_CODE_EXT 4'hf

// ----------------------------------------------------------------------------
// Synchroniser width and blanking after each power-up
// ----------------------------------------------------------------------------
`define VRDC_SYNC_W 4
`define VRDC_BLANK_CYC 2'h3

`endif

// ### src/vrdc_pkg.sv
/*
 * Types of the voltage reference and supply detect control block.
 * Assumes vrdc_defs.svh is reachable on the include path.
 */
`include "vrdc_defs.svh"

package vrdc_pkg;

    // ------------------------------------------------------------------------
    // Whole state of the control module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ladder_ctrl;
        logic fixed_ref_enable;
        logic fixed_ref_power;
        logic fixed_ref_stable;
        logic [1:0] fixed_blank;
        logic detect_direction;
        logic detector_power_enable;
        logic [3:0] trip_point_code;
        logic external_detect_select;
        logic detector_reference_stable;
        logic [1:0] detect_blank;
        logic detector_event_flag;
        logic [7:0] rdata;
    } vrdc_state_t;

endpackage : vrdc_pkg

// ### src/vrdc_sync_if.sv
/*
 * Carrier between the control module and its synchroniser.
 * Assumes the raw bits come from analog circuits outside the clock domain.
 */
`timescale 1ns/1ns
`include "vrdc_defs.svh"

interface vrdc_sync_if;
    logic [`VRDC_SYNC_W-1:0] raw;
    logic [`VRDC_SYNC_W-1:0] synced;
    modport ctrl (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : vrdc_sync_if

// ### src/vrdc_sync.sv
/*
 * Two flip-flop synchroniser for the analog status indications.
 * Assumes each raw bit is a slow level; pulses shorter than a clock are lost.
 */
`timescale 1ns/1ns

module vrdc_sync
    import vrdc_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic resetn,
    vrdc_sync_if.sync sif
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } vrdc_sync_state_t;

    vrdc_sync_state_t s_q;
    vrdc_sync_state_t s_d;

    // The first stage feeds the second stage only.
    always_comb begin
        s_d.meta = sif.raw;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sif.synced = s_q.sync;

endmodule : vrdc_sync

// ### src/vrdc_ctrl.sv
/*
 * Control and status logic for the fixed reference, the reference ladder and
 * the supply detector, reached through three 8-bit registers.
 * Assumes a register master on the same clock and analog indications that
 * arrive asynchronously; the interrupt enable lives outside this block.
 */
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "vrdc_defs.svh"

// Contract
// - Fixed reference enable bit powers reference on.
// - Oscillator, detector or brownout also power it.
// - Fixed stable flag reads powered and settled.
// - Ladder power bit powers ladder up/down.
// - Pin output bit drives pin, overrides direction.
// - Range bit one selects low range.
// - Source bit one selects external reference pins.
// - Four-bit tap value chooses ladder tap.
// - Detector power bit switches detector on/off.
// - Detector stable flag set after each enable.
// - No event flag before detector is stable.
// - Direction bit picks at-or-above or at-or-below.
// - Trip code 1111 selects external detect input.
// - Crossing sets event flag; enabled flag interrupts.
// - Cleared flag sets again while condition persists.
// - Reset disables references, clears ladder fields.
module vrdc_ctrl
    import vrdc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`VRDC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic internal_fast_oscillator_on,
    input wire logic brownout_reset_on,
    input wire logic detector_interrupt_enable,
    input wire logic detector_event_clear,
    input wire logic fixed_ref_ready_raw,
    input wire logic detector_ref_ready_raw,
    input wire logic supply_at_or_above_raw,
    input wire logic supply_at_or_below_raw,
    output logic fixed_ref_power,
    output logic ladder_power,
    output logic ladder_pin_drive,
    output logic port_a_direction_override,
    output logic ladder_range_low,
    output logic ladder_source_ext,
    output logic [3:0] ladder_tap_value,
    output logic detector_power,
    output logic detect_direction,
    output logic [3:0] trip_point_code,
    output logic external_detect_select,
    output logic detector_event_flag,
    output logic detector_irq
);

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    function automatic logic vrdc_hit(
        input logic [`VRDC_ADDR_W-1:0] addr,
        input logic [`VRDC_ADDR_W-1:0] ofs,
        input logic strobe
    );
        vrdc_hit = strobe && (addr == ofs);
    endfunction : vrdc_hit

    function automatic logic [7:0] vrdc_read_value(
        input logic [`VRDC_ADDR_W-1:0] addr,
        input vrdc_state_t st
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `VRDC_OFS_LADDER: begin
                v = st.ladder_ctrl;
            end
            `VRDC_OFS_FIXED: begin
                v[`VRDC_FIX_ENABLE_BIT] = st.fixed_ref_enable;
                v[`VRDC_FIX_STABLE_BIT] = st.fixed_ref_stable;
            end
            `VRDC_OFS_DETECT: begin
                v[`VRDC_DET_DIR_BIT] = st.detect_direction;
                v[`VRDC_DET_STABLE_BIT] = st.detector_reference_stable;
                v[`VRDC_DET_POWER_BIT] = st.detector_power_enable;
                v[`VRDC_DET_CODE_MSB:`VRDC_DET_CODE_LSB] = st.trip_point_code;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        vrdc_read_value = v;
    endfunction : vrdc_read_value

    // ------------------------------------------------------------------------
    // Synchronised analog indications
    // ------------------------------------------------------------------------
    vrdc_sync_if sif ();

    assign sif.raw = {supply_at_or_below_raw, supply_at_or_above_raw,
                      detector_ref_ready_raw, fixed_ref_ready_raw};

    // The analog levels are read only after the second flip-flop.
    vrdc_sync #(
        .W(`VRDC_SYNC_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .sif(sif)
    );

    logic fixed_ready_s;
    logic detect_ready_s;
    logic above_s;
    logic below_s;

    assign fixed_ready_s = sif.synced[0];
    assign detect_ready_s = sif.synced[1];
    assign above_s = sif.synced[2];
    assign below_s = sif.synced[3];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    vrdc_state_t s_q;
    vrdc_state_t s_d;

    logic wr_ladder;
    logic wr_fixed;
    logic wr_detect;
    logic trip_now;
    logic event_set;

    assign wr_ladder = vrdc_hit(reg_addr, `VRDC_OFS_LADDER, reg_write);
    assign wr_fixed = vrdc_hit(reg_addr, `VRDC_OFS_FIXED, reg_write);
    assign wr_detect = vrdc_hit(reg_addr, `VRDC_OFS_DETECT, reg_write);

    // The comparator reports both sides so that equality counts either way.
    assign trip_now = s_q.detect_direction ? above_s : below_s;
    assign event_set = s_q.detector_power_enable && s_q.detector_reference_stable
                       && trip_now;

    always_comb begin
        s_d = s_q;

        // Ladder register is fully writable.
        if (wr_ladder) begin
            s_d.ladder_ctrl = reg_wdata;
        end

        // Only the enable bit is writable; the rest is ignored.
        if (wr_fixed) begin
            s_d.fixed_ref_enable = reg_wdata[`VRDC_FIX_ENABLE_BIT];
        end

        if (wr_detect) begin
            s_d.detect_direction = reg_wdata[`VRDC_DET_DIR_BIT];
            s_d.detector_power_enable = reg_wdata[`VRDC_DET_POWER_BIT];
            s_d.trip_point_code =
                reg_wdata[`VRDC_DET_CODE_MSB:`VRDC_DET_CODE_LSB];
        end

        s_d.external_detect_select =
            (s_d.trip_point_code == `VRDC_DETECT_CODE_EXT);

        // Any client of the reference keeps it powered.
        s_d.fixed_ref_power = s_d.fixed_ref_enable || s_d.detector_power_enable
                              || internal_fast_oscillator_on || brownout_reset_on;

        // A stale ready level from an earlier power-up is blanked out.
        if (!s_q.fixed_ref_power) begin
            s_d.fixed_blank = `VRDC_BLANK_CYC;
            s_d.fixed_ref_stable = 1'b0;
        end else if (s_q.fixed_blank != 2'h0) begin
            s_d.fixed_blank = s_q.fixed_blank - 2'h1;
        end else begin
            s_d.fixed_ref_stable = s_q.fixed_ref_stable || fixed_ready_s;
        end

        // Stability is earned again after every enable.
        if (!s_q.detector_power_enable) begin
            s_d.detect_blank = `VRDC_BLANK_CYC;
            s_d.detector_reference_stable = 1'b0;
        end else if (s_q.detect_blank != 2'h0) begin
            s_d.detect_blank = s_q.detect_blank - 2'h1;
        end else begin
            s_d.detector_reference_stable =
                s_q.detector_reference_stable || detect_ready_s;
        end

        // A new event in the cycle of the clear wins over the clear.
        s_d.detector_event_flag =
            (s_q.detector_event_flag && !detector_event_clear) || event_set;

        // Read data stand for one cycle only; unmapped offsets read zero.
        s_d.rdata = reg_read ? vrdc_read_value(reg_addr, s_q) : 8'h00;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.ladder_ctrl <= `VRDC_LADDER_RESET;
            s_q.fixed_ref_enable <= `VRDC_FIXED_ENABLE_RESET;
            s_q.trip_point_code <= `VRDC_DETECT_CODE_RESET;
            s_q.fixed_blank <= `VRDC_BLANK_CYC;
            s_q.detect_blank <= `VRDC_BLANK_CYC;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign fixed_ref_power = s_q.fixed_ref_power;
    assign ladder_power = s_q.ladder_ctrl[`VRDC_LAD_POWER_BIT];
    assign ladder_pin_drive = s_q.ladder_ctrl[`VRDC_LAD_PIN_BIT];
    // The pin buffer obeys this rather than the port direction bit.
    assign port_a_direction_override = s_q.ladder_ctrl[`VRDC_LAD_PIN_BIT];
    assign ladder_range_low = s_q.ladder_ctrl[`VRDC_LAD_RANGE_BIT];
    assign ladder_source_ext = s_q.ladder_ctrl[`VRDC_LAD_SOURCE_BIT];
    assign ladder_tap_value =
        s_q.ladder_ctrl[`VRDC_LAD_TAP_MSB:`VRDC_LAD_TAP_LSB];
    assign detector_power = s_q.detector_power_enable;
    assign detect_direction = s_q.detect_direction;
    assign trip_point_code = s_q.trip_point_code;
    assign external_detect_select = s_q.external_detect_select;
    assign detector_event_flag = s_q.detector_event_flag;
    assign detector_irq = s_q.detector_event_flag && detector_interrupt_enable;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_fixed_write_on;
        wr_fixed && reg_wdata[`VRDC_FIX_ENABLE_BIT];
    endsequence

    property p_fixed_enable_power;
        @(posedge clk) disable iff (!resetn)
        s_fixed_write_on |=> fixed_ref_power && s_q.fixed_ref_enable;
    endproperty
    a_fixed_enable_power: assert property (p_fixed_enable_power)
        else $error("fixed reference not powered after enable write");

    property p_fixed_other_power;
        @(posedge clk) disable iff (!resetn)
        (internal_fast_oscillator_on || brownout_reset_on || s_d.detector_power_enable)
        |=> fixed_ref_power;
    endproperty
    a_fixed_other_power: assert property (p_fixed_other_power)
        else $error("fixed reference off while a client needs it");

    property p_fixed_stable;
        @(posedge clk) disable iff (!resetn)
        $rose(s_q.fixed_ref_stable) |-> $past(fixed_ref_power, 4) && fixed_ref_power;
    endproperty
    a_fixed_stable: assert property (p_fixed_stable)
        else $error("fixed stable flag rose without settled power");

    property p_ladder_write;
        @(posedge clk) disable iff (!resetn)
        wr_ladder |=> ladder_power == $past(reg_wdata[7])
                      && ladder_pin_drive == $past(reg_wdata[6])
                      && ladder_range_low == $past(reg_wdata[5])
                      && ladder_source_ext == $past(reg_wdata[4])
                      && ladder_tap_value == $past(reg_wdata[3:0]);
    endproperty
    a_ladder_write: assert property (p_ladder_write)
        else $error("ladder outputs do not follow the written value");

    property p_pin_override;
        @(posedge clk) disable iff (!resetn)
        ladder_pin_drive |-> port_a_direction_override;
    endproperty
    a_pin_override: assert property (p_pin_override)
        else $error("pin drive without direction override");

    property p_detector_power;
        @(posedge clk) disable iff (!resetn)
        wr_detect |=> detector_power == $past(reg_wdata[4])
                      && detect_direction == $past(reg_wdata[7]);
    endproperty
    a_detector_power: assert property (p_detector_power)
        else $error("detector power or direction not updated");

    sequence s_detect_ready_seen;
        $past(detector_ref_ready_raw, 3) && $past(detector_power, 1);
    endsequence

    property p_detect_stable;
        @(posedge clk) disable iff (!resetn)
        $rose(s_q.detector_reference_stable) |-> s_detect_ready_seen;
    endproperty
    a_detect_stable: assert property (p_detect_stable)
        else $error("detector stable flag rose without synchronised ready");

    property p_no_early_event;
        @(posedge clk) disable iff (!resetn)
        $rose(detector_event_flag) |-> $past(s_q.detector_reference_stable);
    endproperty
    a_no_early_event: assert property (p_no_early_event)
        else $error("event flag set before detector was stable");

    property p_event_set;
        @(posedge clk) disable iff (!resetn)
        event_set |=> detector_event_flag;
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("trip condition did not set the event flag");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
        detector_irq |-> detector_event_flag && detector_interrupt_enable;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request without enabled flag");

    property p_ext_select;
        @(posedge clk) disable iff (!resetn)
        (wr_detect && reg_wdata[3:0] == 4'hf) |=> external_detect_select;
    endproperty
    a_ext_select: assert property (p_ext_select)
        else $error("code 1111 did not select external input");

    property p_reset_values;
        @(posedge clk) disable iff (!resetn)
        !$past(resetn) |-> !ladder_power && !ladder_pin_drive && !ladder_range_low
                           && ladder_tap_value == 4'h0 && !s_q.fixed_ref_enable;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong after release");

    property p_unused_zero;
        @(posedge clk) disable iff (!resetn)
        (reg_read && reg_addr == `VRDC_OFS_FIXED) |=> reg_rdata[5:0] == 6'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unimplemented bits read nonzero");

    property p_read_one_cycle;
        @(posedge clk) disable iff (!resetn)
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle)
        else $error("read data present without a read");

endmodule : vrdc_ctrl

// ### sim/vrdc_ctrl_bench.sv
/*
 * Self-checking bench for the voltage reference and supply detect control block.
 * Assumes the design checks its own assertions and that the bench drives every
 * port, including the analog levels, at rising clock edges.
 */
`timescale 1ns/1ns
`include "vrdc_defs.svh"

module vrdc_ctrl_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [`VRDC_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic osc_on = 1'b0;
    logic brownout_on = 1'b0;
    logic irq_en = 1'b0;
    logic ev_clr = 1'b0;
    logic fix_rdy = 1'b0;
    logic det_rdy = 1'b0;
    logic above = 1'b0;
    logic below = 1'b0;
    logic fixed_ref_power, ladder_power, ladder_pin_drive, port_a_direction_override;
    logic ladder_range_low, ladder_source_ext, detector_power, detect_direction;
    logic external_detect_select, detector_event_flag, detector_irq;
    logic [3:0] ladder_tap_value, trip_point_code;
    logic [7:0] v;
    logic [7:0] lv [4] = '{8'hc5, 8'h3a, 8'h8f, 8'h70};
    int num_errors = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    vrdc_ctrl vrdc_ctrl_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .internal_fast_oscillator_on(osc_on), .brownout_reset_on(brownout_on),
        .detector_interrupt_enable(irq_en), .detector_event_clear(ev_clr),
        .fixed_ref_ready_raw(fix_rdy), .detector_ref_ready_raw(det_rdy),
        .supply_at_or_above_raw(above), .supply_at_or_below_raw(below),
        .fixed_ref_power(fixed_ref_power), .ladder_power(ladder_power),
        .ladder_pin_drive(ladder_pin_drive),
        .port_a_direction_override(port_a_direction_override),
        .ladder_range_low(ladder_range_low), .ladder_source_ext(ladder_source_ext),
        .ladder_tap_value(ladder_tap_value), .detector_power(detector_power),
        .detect_direction(detect_direction), .trip_point_code(trip_point_code),
        .external_detect_select(external_detect_select),
        .detector_event_flag(detector_event_flag), .detector_irq(detector_irq)
    );

    // ------------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------------
    task test_done;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle right after the strobe edge.
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task poll(input logic [1:0] a, input logic [7:0] mask);
        int i;
        logic [7:0] d;
        d = 8'h00;
        for (i = 0; i < 20 && (d & mask) !== mask; i++) rd(a, d);
        if ((d & mask) !== mask) begin
            num_errors++;
            test_done();
        end
    endtask : poll

    task wait_flag;
        int i;
        for (i = 0; i < 8 && detector_event_flag !== 1'b1; i++) cyc(1);
        if (detector_event_flag !== 1'b1) begin
            num_errors++;
            test_done();
        end
    endtask : wait_flag

    task pulse_clear;
        @(posedge clk);
        ev_clr <= 1'b1;
        @(posedge clk);
        ev_clr <= 1'b0;
        #1;
    endtask : pulse_clear

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk({ladder_power, ladder_pin_drive, ladder_range_low, ladder_source_ext,
            ladder_tap_value}, 8'h00);
        chk(trip_point_code, 8'h05);
        chk({fixed_ref_power, detector_power, detector_event_flag}, 8'h00);
        rd(0, v); chk(v, 8'h00);
        rd(1, v); chk(v, 8'h00);
        rd(2, v); chk(v, 8'h05);
        foreach (lv[i]) begin
            wr(0, lv[i]);
            chk({ladder_power, ladder_pin_drive, ladder_range_low, ladder_source_ext,
                ladder_tap_value}, lv[i]);
            chk(port_a_direction_override, lv[i][6]);
            rd(0, v); chk(v, lv[i]);
        end
        // Writes to the unmapped offset must not alias onto the ladder register, the only one read back here.
        wr(3, 8'hff);
        rd(3, v); chk(v, 8'h00);
        rd(0, v); chk(v, 8'h70);
        wr(1, 8'hff);
        chk(fixed_ref_power, 1'b1);
        rd(1, v); chk(v, 8'h80);
        @(posedge clk);
        fix_rdy <= 1'b1;
        poll(1, 8'h40);
        wr(1, 8'h00);
        chk(fixed_ref_power, 1'b0);
        rd(1, v); chk(v, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            osc_on <= (k == 0);
            brownout_on <= (k == 1);
            cyc(2); chk(fixed_ref_power, 1'b1);
        end
        @(posedge clk);
        brownout_on <= 1'b0;
        above <= 1'b1;
        cyc(2); chk(fixed_ref_power, 1'b0);
        wr(2, 8'hff);
        chk({detector_power, fixed_ref_power, detect_direction}, 8'h07);
        chk({external_detect_select, trip_point_code}, 8'h1f);
        cyc(10); chk(detector_event_flag, 1'b0);
        rd(2, v); chk(v, 8'h9f);
        @(posedge clk);
        det_rdy <= 1'b1;
        poll(2, 8'h20);
        wait_flag();
        chk(detector_irq, 1'b0);
        @(posedge clk);
        irq_en <= 1'b1;
        #1;
        chk(detector_irq, 1'b1);
        pulse_clear();
        cyc(2); chk(detector_event_flag, 1'b1);
        @(posedge clk);
        above <= 1'b0;
        cyc(4);
        pulse_clear();
        chk({detector_event_flag, detector_irq}, 8'h00);
        wr(2, 8'h1e);
        @(posedge clk);
        above <= 1'b1;
        cyc(6); chk(detector_event_flag, 1'b0);
        @(posedge clk);
        below <= 1'b1;
        cyc(1); chk(detector_event_flag, 1'b0);
        wait_flag();
        chk(external_detect_select, 1'b0);
        for (int c = 0; c < 15; c++) begin
            wr(2, {4'h1, c[3:0]});
            chk({external_detect_select, trip_point_code}, {4'h0, c[3:0]});
        end
        wr(2, 8'h05);
        rd(2, v); chk(v, 8'h05);
        wr(2, 8'h10);
        poll(2, 8'h20);
        // Reset is asynchronous, so the outputs take their reset values before the next edge.
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        chk({ladder_power, ladder_pin_drive, ladder_range_low, ladder_tap_value},
            8'h00);
        chk({fixed_ref_power, detector_event_flag, trip_point_code}, 8'h05);
        cyc(2);
        test_done();
    end
endmodule : vrdc_ctrl_bench
